// [bench/slot_bus_node_sva.sv]
// Port-level checker for the slotted bus node, bound to its top module.
// Assumes the master link outputs and the Avalon port are the only view.
`timescale 1ns/10ps
`default_nettype none
module slot_bus_node_sva
  import slot_bus_pkg::*;
(
  input wire logic              clk_sys,
  input wire logic              nrst,
  input wire logic [ADDR_W-1:0] address,
  input wire logic              read,
  input wire logic              write,
  input wire logic [31:0]       writedata,
  input wire logic [3:0]        byteenable,
  input wire logic [31:0]       readdata,
  input wire logic              waitrequest,
  input wire bus_in_type        bus_in,
  input wire bus_out_type       bus_out,
  input wire logic [15:0]       src_word,
  input wire logic              src_taken
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  logic [7:0] flm;    // Shadow of frame_length_minus_one
  logic       ena;    // Shadow of strobe_drive_enable
  logic [8:0] cells;  // Cells seen in the current outgoing frame
  logic       stb_q;  // Strobe one cycle ago
  wire        len_wr = write && !waitrequest && address == OFS_FRAME_LENGTH;
  // Shadow registers follow accepted writes; cells restart outside frames
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      flm   <= 8'h00;
      ena   <= 1'b0;
      cells <= 9'h000;
      stb_q <= 1'b0;
    end else begin
      if (len_wr && byteenable[0]) flm <= writedata[7:0];
      if (len_wr && byteenable[1]) ena <= writedata[BIT_ENABLE];
      cells <= bus_out.frame_n ? 9'h000 :
               cells + {8'h00, bus_out.cell_strobe && !stb_q};
      stb_q <= bus_out.cell_strobe;
    end
  end
  // One wait state, then the answer in the following cycle
  sequence one_wait;
    waitrequest ##1 !waitrequest;
  endsequence
  chk_frame_lead: assert property ($fell(bus_out.frame_n) |->
    !bus_out.cell_strobe [*2]) else $error("window lead too short");
  chk_frame_hold: assert property ($fell(bus_out.cell_strobe) |->
    !bus_out.frame_n [*4]) else $error("window dropped too early");
  chk_frame_gap: assert property ($rose(bus_out.frame_n) |->
    bus_out.frame_n [*3]) else $error("window gap too short");
  chk_data_stands: assert property (
    $rose(bus_out.cell_strobe) && !bus_out.data_oe_n |=>
    $stable(bus_out.data) && !bus_out.data_oe_n)
    else $error("data moved inside half cell");
  chk_strobe_window: assert property (
    bus_out.cell_strobe |-> !bus_out.frame_n)
    else $error("strobe outside window");
  chk_strobe_drive: assert property (
    $stable(ena) ##1 $stable(ena) |-> bus_out.strobe_oe_n == !ena)
    else $error("strobe enable not followed");
  chk_cell_count: assert property ($rose(bus_out.frame_n) |->
    cells == {1'b0, flm} + 9'h001) else $error("wrong cell count");
  chk_bus_answer: assert property ($rose(read || write) |-> one_wait)
    else $error("bus answer timing wrong");
endmodule
bind slot_bus_node slot_bus_node_sva chk_u (.clk_sys(clk_sys),
  .nrst(nrst), .address(address), .read(read), .write(write),
  .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
  .waitrequest(waitrequest), .bus_in(bus_in), .bus_out(bus_out),
  .src_word(src_word), .src_taken(src_taken));
`default_nettype wire

// [bench/slot_bus_node_tb_top.sv]
// Self-checking bench for the slotted bus node: Avalon register access,
// outgoing master frames and incoming frames from the partner model.
`timescale 1ns/10ps
`default_nettype none
module slot_bus_node_tb_top;
  import slot_bus_pkg::*;
  logic              clk_sys;     // 25 MHz system clock
  logic              nrst;        // Asynchronous reset, low true
  logic [ADDR_W-1:0] address;     // Avalon request lines
  logic              read;
  logic              write;
  logic [31:0]       writedata;
  logic [3:0]        byteenable;
  logic [31:0]       readdata;
  logic              waitrequest;
  bus_in_type        bus_in;      // From the partner
  bus_out_type       bus_out;     // Toward the left
  logic [15:0]       src_word;    // Word inserted in own slots
  logic              src_taken;
  int                err_total;
  int                num_checks;
  int                own_cnt;     // Own slots seen
  int                cell_cnt;    // Outgoing cells seen
  logic              stb_q;

  slot_bus_node dut_u (.clk_sys(clk_sys), .nrst(nrst), .address(address),
    .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .bus_in(bus_in), .bus_out(bus_out),
    .src_word(src_word), .src_taken(src_taken));
  slot_partner part_u (.bus_in(bus_in));

  // Clock
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // Compare and count
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One Avalon access; request held until waitrequest is low at an edge
  task automatic acc(input logic wr, input logic [6:0] a,
                     input logic [15:0] d, output logic [31:0] q);
    @(posedge clk_sys);
    address   <= a;
    writedata <= {16'h0000, d};
    write     <= wr;
    read      <= ~wr;
    do begin
      @(posedge clk_sys);
    end while (waitrequest !== 1'b0);
    q = readdata;
    write <= 1'b0;
    read  <= 1'b0;
  endtask

  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    logic [31:0] q;
    acc(1'b1, a, d, q);
  endtask

  task automatic rc(input logic [6:0] a, input logic [15:0] e);
    logic [31:0] q;
    acc(1'b0, a, 16'h0000, q);
    check($sformatf("reg %h", a), q, {16'h0000, e});
  endtask

  task automatic results();
    if (err_total == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Outgoing link monitor: bytes of own slots and cell count
  always @(negedge clk_sys) begin
    if (src_taken === 1'b1) own_cnt++;
    if (bus_out.cell_strobe === 1'b1 && stb_q === 1'b0) begin
      cell_cnt++;
      if (bus_out.data_oe_n === 1'b0)
        check("low byte", 32'(bus_out.data), 32'h5A);
    end
    if (bus_out.cell_strobe === 1'b0 && stb_q === 1'b1 &&
        bus_out.data_oe_n === 1'b0)
      check("high byte", 32'(bus_out.data), 32'hA5);
    stb_q = bus_out.cell_strobe;
  end

  // Watchdog
  initial begin
    #100000;
    err_total++;
    results();
  end

  // Main sequence
  initial begin
    nrst = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 7'h00;
    writedata = 32'h00000000;
    byteenable = 4'h3;
    src_word = 16'hA55A;
    err_total = 0;
    num_checks = 0;
    own_cnt = 0;
    cell_cnt = 0;
    stb_q = 1'b0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    // Reset values and idle link
    rc(OFS_SLOT_PLACEMENT, 16'h0000);
    rc(OFS_FRAME_LENGTH, 16'h0000);
    rc(OFS_FRAME_DECIM, 16'h0000);
    check("strobe oe", 32'(bus_out.strobe_oe_n), 32'h1);
    // Start slot 1, skip 2, eight cells, strobes on
    wr(OFS_SLOT_PLACEMENT, 16'h0201);
    wr(OFS_FRAME_LENGTH, 16'h0107);
    for (int k = 0; k < 16; k++)
      wr(OFS_PASS_MASK_BASE + 7'(4 * k), k == 0 ? 16'h000B :
         (k == 1 ? 16'h0001 : 16'h0000));
    wr(OFS_FRAME_DECIM, 16'h0101);
    rc(OFS_SLOT_PLACEMENT, 16'h0201);
    rc(OFS_FRAME_LENGTH, 16'h0107);
    wr(7'h20, 16'hFFFF);
    rc(7'h20, 16'h0000);
    check("strobe oe", 32'(bus_out.strobe_oe_n), 32'h0);
    // One tick gives one frame with own slots 1, 4 and 7
    part_u.tick();
    check("sample clock", 32'(bus_out.sample_clock), 32'h1);
    repeat (60) @(posedge clk_sys);
    check("cells", 32'(cell_cnt), 32'd8);
    check("own slots", 32'(own_cnt), 32'd3);
    // Three frames in, every other one kept, words 0, 1, 3, 16 pass
    part_u.frame(16'h1000, 17);
    part_u.frame(16'h1100, 17);
    part_u.frame(16'h1200, 17);
    repeat (10) @(posedge clk_sys);
    rc(OFS_FRAME_COUNT, 16'h0002);
    rc(OFS_CUR_FRAME_PTR, 16'h0004);
    wr(OFS_BUF_READ_ADDR, 16'h0004);
    rc(OFS_BUF_READ_DATA, 16'h1200);
    wr(OFS_BUF_READ_ADDR, 16'h0007);
    rc(OFS_BUF_READ_DATA, 16'h1210);
    // Capture off stores nothing
    wr(OFS_FRAME_DECIM, 16'h0000);
    part_u.frame(16'h1300, 17);
    repeat (10) @(posedge clk_sys);
    rc(OFS_FRAME_COUNT, 16'h0002);
    wr(OFS_FRAME_COUNT, 16'h0001);
    rc(OFS_FRAME_COUNT, 16'h0001);
    // Strobes released
    wr(OFS_FRAME_LENGTH, 16'h0007);
    repeat (3) @(posedge clk_sys);
    check("strobe oe", 32'(bus_out.strobe_oe_n), 32'h1);
    results();
  end
endmodule
`default_nettype wire

// [bench/slot_partner.sv]
// Right-hand master source model driving the node's incoming link.
// Assumes a 320 ns cell and asynchronous timing from its own delays.
`timescale 1ns/10ps
`default_nettype none
module slot_partner
  import slot_bus_pkg::*;
(
  output bus_in_type bus_in
);
  // Idle: window negated, strobe and clock low
  initial bus_in = 11'h002;
  // One sample tick
  task automatic tick();
    bus_in.sample_clock = 1'b1;
    #160;
    bus_in.sample_clock = 1'b0;
  endtask
  // Frame of n words counting up from base
  task automatic frame(input logic [15:0] base, input int n);
    logic [15:0] w;
    bus_in.frame_n = 1'b0;
    #80;
    for (int i = 0; i < n; i++) begin
      w = base + 16'(i);
      bus_in.data = w[7:0];
      bus_in.cell_strobe = 1'b1;
      #160;
      bus_in.data = w[15:8];
      bus_in.cell_strobe = 1'b0;
      #160;
    end
    #210;
    bus_in.frame_n = 1'b1;
    // Released data lines settle high through the bus termination
    bus_in.data = 8'hFF;
    #120;
  endtask
endmodule
`default_nettype wire

// [hw/slot_bus_node.sv]
// Local bus node: sink with frame decimation, word pass mask and 32K
// circular delay buffer on the right, master source on the left.
// Assumes Avalon-MM register access and asynchronous bus lines.
//
// The placing of the registers and the Avalon-MM register port were decided locally.
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - Frame window leads first strobe by 50 ns
// - Window held cell plus 50 ns after end
// - Window stays negated 100 ns between frames
// - Driven data set with each strobe edge, held for its half cell
// - Received strobe delayed 50 ns before latching
// - Data high true, window low, both edges
// - Terminate right bus, master the left
// - First insertion at slot_start, zero is first
// - Slot skip gives slots skipped between insertions
// - Frame length field is word count minus one
// - Strobes driven only when strobe_drive_enable set
// - Sixteen mask words, one bit per word
// - Frame interval N keeps one frame in N+1
// - Nothing stored while capture_enable is clear
// - Each conversion tick seen in idle starts a new frame
// - Circular 32K buffer with latest frame pointer
// - Low byte on rising, high on falling edge
// - Slot count of trailing edges, cleared on tick
// - One fixed-length frame per sample tick; ticks outside idle are dropped
module slot_bus_node
  import slot_bus_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              nrst,
  input  wire logic [ADDR_W-1:0] address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [31:0]       writedata,
  input  wire logic [3:0]        byteenable,
  output logic      [31:0]       readdata,
  output logic                   waitrequest,
  input  wire bus_in_type        bus_in,
  output bus_out_type            bus_out,
  input  wire logic [15:0]       src_word,
  output logic                   src_taken
);

  // All state of the node except the memories and their read port
  typedef struct packed {
    logic [1:0]        tick_sync;    // Sample clock synchroniser
    logic              tick_prev;    // Edge detector for the tick
    logic [1:0]        stb_sync;     // Cell strobe synchroniser
    logic [STROBE_DELAY_CYC:0] stb_dly; // Strobe delay line
    logic [1:0]        fr_sync;      // Frame window synchroniser
    logic              fr_prev;
    logic [7:0]        dat_meta;     // Data synchroniser stages
    logic [7:0]        dat_sync;
    logic [15:0]       slot_placement;
    logic [15:0]       frame_length_control;
    logic [15:0]       frame_decimation_control;
    logic [7:0]        decim_cnt;    // Frames left before next kept one
    logic              frame_sel;    // Current received frame is kept
    logic [8:0]        rx_word;      // Word position in received frame
    logic [7:0]        rx_low;       // Low byte awaiting its high byte
    logic [BUF_AW-1:0] wr_ptr;
    logic [BUF_AW-1:0] frame_start;
    logic [BUF_AW-1:0] cur_frame_ptr;
    logic              frame_wrote;
    logic [15:0]       frame_count;
    logic [BUF_AW-1:0] buf_raddr;
    master_state_type  mstate;
    logic [TIMER_W-1:0] timer;
    logic [7:0]        slot;         // Current transmitted slot
    logic [8:0]        next_ins;     // Next slot we insert into
    logic              own;          // This cell is one of ours
    logic [15:0]       tx_word;
    logic              taken;
    bus_out_type       out;
    logic              ack;          // Bus answer phase
    logic [31:0]       rdata;
  } state_type;

  state_type st;       // Registered state
  state_type next_st;  // Value for the next edge

  // Memories kept outside the struct; they need no reset
  logic [15:0] pass_mask [MASK_WORDS];
  logic [15:0] delay_buf [2**BUF_AW];
  logic [15:0] buf_rdata;              // Registered buffer read port

  // Write strobes computed by the combinational process
  logic              buf_we;
  logic              mask_we;
  logic [MASK_IW-1:0] mask_idx;
  logic [15:0]       mask_wd;

  // Lane-wise merge of a 16-bit register with write data
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0]  be);
    logic [15:0] r;
    r = old;
    if (be[0]) begin
      r[7:0] = wd[7:0];
    end
    if (be[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction

  // Mask word under the bus address, decoded for both read and write
  logic              mask_hit;
  logic [MASK_IW-1:0] mask_addr;
  // Compared in eight bits: the block end overflows the 7-bit address
  assign mask_hit  = (address >= OFS_PASS_MASK_BASE) &&
                     ({1'b0, address} <
                      ({1'b0, OFS_PASS_MASK_BASE} + 8'(4 * MASK_WORDS)));
  assign mask_addr = MASK_IW'((address - OFS_PASS_MASK_BASE) >> 2);

  // Next-state logic for sink, master and register bus
  always_comb begin
    logic stb_rise;
    logic stb_fall;
    logic fr_on;
    logic fr_start;
    logic fr_end;
    logic tick;
    logic [15:0] word;
    logic [31:0] rd;
    stb_rise = 1'b0;
    stb_fall = 1'b0;
    fr_on    = 1'b0;
    fr_start = 1'b0;
    fr_end   = 1'b0;
    tick     = 1'b0;
    word     = 16'h0000;
    rd       = 32'h00000000;
    next_st  = st;
    buf_we   = 1'b0;
    mask_we  = 1'b0;
    mask_idx = mask_addr;
    mask_wd  = 16'h0000;

    // Two flops on every line from outside before any logic
    next_st.tick_sync = {st.tick_sync[0], bus_in.sample_clock};
    next_st.tick_prev = st.tick_sync[1];
    next_st.stb_sync  = {st.stb_sync[0], bus_in.cell_strobe};
    next_st.fr_sync   = {st.fr_sync[0], bus_in.frame_n};
    next_st.fr_prev   = st.fr_sync[1];
    next_st.dat_meta  = bus_in.data;
    next_st.dat_sync  = st.dat_meta;
    // Strobe runs one delay stage behind the data
    next_st.stb_dly   = {st.stb_dly[STROBE_DELAY_CYC-1:0],
                         st.stb_sync[1]};

    // Edge detection on synchronised lines only
    tick     = st.tick_sync[1] & ~st.tick_prev;
    fr_on    = ~st.fr_sync[1];
    fr_start = ~st.fr_sync[1] & st.fr_prev;
    fr_end   = st.fr_sync[1] & ~st.fr_prev;
    // Delay line taps: last stage is the used strobe, one before it new
    stb_rise = st.stb_dly[STROBE_DELAY_CYC - 1] &
               ~st.stb_dly[STROBE_DELAY_CYC];
    stb_fall = ~st.stb_dly[STROBE_DELAY_CYC - 1] &
               st.stb_dly[STROBE_DELAY_CYC];

    // ---------------- Sink side (right-hand bus ends here) ----------
    // Frame start picks the kept frames by the interval counter
    if (fr_start) begin
      next_st.rx_word     = 9'h000;
      next_st.frame_start = st.wr_ptr;
      next_st.frame_wrote = 1'b0;
      if (st.decim_cnt == 8'h00) begin
        next_st.frame_sel = 1'b1;
        next_st.decim_cnt =
          st.frame_decimation_control[FLD_LO_MSB:0];
      end else begin
        next_st.frame_sel = 1'b0;
        next_st.decim_cnt = st.decim_cnt - 8'h01;
      end
    end
    // Strobe edges count only inside the window
    if (fr_on && stb_rise) begin
      next_st.rx_low = st.dat_sync;
    end
    if (fr_on && stb_fall) begin
      word = {st.dat_sync, st.rx_low};
      if (st.rx_word != 9'h100) begin
        next_st.rx_word = st.rx_word + 9'h001;
      end
      // Store only a passed word of a kept frame while capturing
      if (st.frame_decimation_control[BIT_ENABLE] &&
          st.frame_sel && !st.rx_word[8] &&
          pass_mask[st.rx_word[7:4]][st.rx_word[3:0]]) begin
        buf_we              = 1'b1;
        next_st.wr_ptr      = st.wr_ptr + 1'b1;
        next_st.frame_wrote = 1'b1;
      end
    end
    // A frame that stored anything becomes the latest frame
    if (fr_end && st.frame_wrote) begin
      next_st.cur_frame_ptr = st.frame_start;
      next_st.frame_count   = st.frame_count + 16'h0001;
    end

    // ---------------- Master source side (left-hand bus) -----------
    next_st.taken = 1'b0;
    case (st.mstate)
      M_IDLE: begin
        // A tick opens a frame; slot count and insertion restart
        if (tick) begin
          next_st.out.frame_n = 1'b0;
          next_st.slot        = 8'h00;
          next_st.next_ins    =
            {1'b0, st.slot_placement[FLD_LO_MSB:0]};
          next_st.timer       = TIMER_W'(FRAME_SETUP_CYC - 1);
          next_st.mstate      = M_SETUP;
        end
      end
      M_SETUP: begin
        // Window leads the first strobe edge by the setup time
        if (st.timer == '0) begin
          next_st.own            = ({1'b0, st.slot} == st.next_ins);
          next_st.tx_word        = src_word;
          next_st.out.cell_strobe = 1'b1;
          next_st.out.data       = src_word[7:0];
          next_st.out.data_oe_n  = ~({1'b0, st.slot} == st.next_ins);
          next_st.timer          = TIMER_W'(HALF_CELL_CYC - 1);
          next_st.mstate         = M_HIGH;
        end else begin
          next_st.timer = st.timer - 1'b1;
        end
      end
      M_HIGH: begin
        // Falling strobe carries the high byte of the same word
        if (st.timer == '0) begin
          next_st.out.cell_strobe = 1'b0;
          next_st.out.data       = st.tx_word[15:8];
          next_st.timer          = TIMER_W'(HALF_CELL_CYC - 1);
          next_st.mstate         = M_LOW;
        end else begin
          next_st.timer = st.timer - 1'b1;
        end
      end
      M_LOW: begin
        if (st.timer == '0) begin
          // Cell done: count the trailing edge, step our slot
          next_st.slot = st.slot + 8'h01;
          if (st.own) begin
            next_st.taken    = 1'b1;
            next_st.next_ins = st.next_ins + 9'h001 +
              {1'b0, st.slot_placement[15:FLD_HI_LSB]};
          end
          if (st.slot == st.frame_length_control[FLD_LO_MSB:0]) begin
            next_st.out.data_oe_n = 1'b1;
            next_st.own    = 1'b0;
            next_st.timer  = TIMER_W'(FRAME_HOLD_CYC - 1);
            next_st.mstate = M_HOLD;
          end else begin
            next_st.own = ({1'b0, st.slot + 8'h01} == next_st.next_ins);
            next_st.tx_word         = src_word;
            next_st.out.cell_strobe = 1'b1;
            next_st.out.data        = src_word[7:0];
            next_st.out.data_oe_n   = ~next_st.own;
            next_st.timer  = TIMER_W'(HALF_CELL_CYC - 1);
            next_st.mstate = M_HIGH;
          end
        end else begin
          next_st.timer = st.timer - 1'b1;
        end
      end
      M_HOLD: begin
        // Window held a cell time plus margin past the last cell
        if (st.timer == '0) begin
          next_st.out.frame_n = 1'b1;
          next_st.timer  = TIMER_W'(FRAME_GAP_CYC - 1);
          next_st.mstate = M_GAP;
        end else begin
          next_st.timer = st.timer - 1'b1;
        end
      end
      M_GAP: begin
        // Ticks in the gap are dropped so the gap is never cut short
        if (st.timer == '0) begin
          next_st.mstate = M_IDLE;
        end else begin
          next_st.timer = st.timer - 1'b1;
        end
      end
      default: begin
        next_st.mstate = M_IDLE;
      end
    endcase
    // Sample clock repeated leftward from the synchronised input
    next_st.out.sample_clock = st.tick_sync[1];
    // Strobes float unless software enables driving them
    next_st.out.strobe_oe_n =
      ~st.frame_length_control[BIT_ENABLE];

    // ---------------- Avalon-MM slave -------------------------------
    // First cycle of a request loads read data; the second answers
    next_st.ack = (read | write) & ~st.ack;
    if ((read | write) && !st.ack) begin
      case (address)
        OFS_SLOT_PLACEMENT: rd = {16'h0000, st.slot_placement};
        OFS_FRAME_LENGTH:   rd = {16'h0000, st.frame_length_control};
        OFS_FRAME_DECIM:    rd = {16'h0000, st.frame_decimation_control};
        OFS_CUR_FRAME_PTR:  rd = {17'h00000, st.cur_frame_ptr};
        OFS_FRAME_COUNT:    rd = {16'h0000, st.frame_count};
        OFS_BUF_READ_ADDR:  rd = {17'h00000, st.buf_raddr};
        OFS_BUF_READ_DATA:  rd = {16'h0000, buf_rdata};
        OFS_STATUS: begin
          rd = {29'h00000000, st.frame_sel, fr_on,
                (st.mstate != M_IDLE)};
        end
        default: begin
          // Unmapped offsets read as zero
          rd = mask_hit ? {16'h0000, pass_mask[mask_addr]} : 32'h0;
        end
      endcase
      next_st.rdata = rd;
    end
    // Writes take effect on the answering edge only
    if (write && st.ack) begin
      case (address)
        OFS_SLOT_PLACEMENT: begin
          next_st.slot_placement =
            merge16(st.slot_placement, writedata, byteenable);
        end
        OFS_FRAME_LENGTH: begin
          // Must hold a correct length before the master runs
          next_st.frame_length_control =
            merge16(st.frame_length_control, writedata, byteenable) &
            16'h01FF;
        end
        OFS_FRAME_DECIM: begin
          next_st.frame_decimation_control =
            merge16(st.frame_decimation_control, writedata, byteenable) &
            16'h01FF;
          next_st.decim_cnt = 8'h00;
        end
        OFS_FRAME_COUNT: begin
          // Software consumes one frame; a new frame at once still counts
          if (byteenable[0]) begin
            next_st.frame_count = next_st.frame_count - 16'h0001;
          end
        end
        OFS_BUF_READ_ADDR: begin
          next_st.buf_raddr = BUF_AW'(writedata[BUF_AW-1:0]);
        end
        default: begin
          if (mask_hit) begin
            mask_we = 1'b1;
            mask_wd = merge16(pass_mask[mask_addr], writedata, byteenable);
          end
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
      st.tick_prev <= 1'b0;
      st.fr_sync <= 2'b11;
      st.fr_prev <= 1'b1;
      st.mstate <= M_IDLE;
      st.slot_placement <= RST_CTRL;
      st.frame_length_control <= RST_CTRL;
      st.frame_decimation_control <= RST_CTRL;
      st.out.frame_n <= 1'b1;
      st.out.data_oe_n <= 1'b1;
      st.out.strobe_oe_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Delay buffer and pass mask storage, with a registered read port
  always_ff @(posedge clk_sys) begin
    if (buf_we) begin
      delay_buf[st.wr_ptr] <= {st.dat_sync, st.rx_low};
    end
    if (mask_we) begin
      pass_mask[mask_idx] <= mask_wd;
    end
    buf_rdata <= delay_buf[st.buf_raddr];
  end

  // Outputs straight from the state; waitrequest also from read and write
  assign readdata    = st.rdata;
  assign waitrequest = (read | write) & ~st.ack;
  assign bus_out     = st.out;
  assign src_taken   = st.taken;

endmodule

`default_nettype wire

// [hw/slot_bus_pkg.sv]
// Constants, field layouts and carrier types for the slotted byte-serial
// local bus sink and master source.
// Assumes a 25 MHz system clock; all link timing is counted in its cycles.
package slot_bus_pkg;

  // System clock period
  localparam int CLK_NS = 40;

  // Link timing figures, in nanoseconds
  localparam int HALF_CELL_NS    = 50;   // One strobe phase (byte)
  localparam int CELL_NS         = 100;  // Whole byte cell
  localparam int FRAME_SETUP_NS  = 50;   // Window before first strobe
  localparam int FRAME_HOLD_NS   = CELL_NS + 50; // After last trailing edge
  localparam int FRAME_GAP_NS    = 100;  // Window negated between frames
  localparam int STROBE_DELAY_NS = 50;   // Receive strobe delay
  localparam int STROBE_TOL_NS   = 20;   // Allowed error of that delay

  // Least times round up to whole cycles
  localparam int HALF_CELL_CYC   = (HALF_CELL_NS + CLK_NS - 1) / CLK_NS;
  localparam int FRAME_SETUP_CYC = (FRAME_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int FRAME_HOLD_CYC  = (FRAME_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int FRAME_GAP_CYC   = (FRAME_GAP_NS + CLK_NS - 1) / CLK_NS;
  // Longest allowed delay rounds down
  localparam int STROBE_DELAY_CYC =
    (STROBE_DELAY_NS + STROBE_TOL_NS) / CLK_NS;

  // Widths
  localparam int TIMER_W    = 3;
  localparam int BUF_AW     = 15;        // 32K sample delay buffer
  localparam int MASK_WORDS = 16;        // 16 x 16 = 256 pass bits
  localparam int MASK_IW    = 4;
  localparam int ADDR_W     = 7;

  // Register byte offsets
  localparam logic [6:0] OFS_SLOT_PLACEMENT  = 7'h00;
  localparam logic [6:0] OFS_FRAME_LENGTH    = 7'h04;
  localparam logic [6:0] OFS_FRAME_DECIM     = 7'h08;
  localparam logic [6:0] OFS_CUR_FRAME_PTR   = 7'h0C;
  localparam logic [6:0] OFS_FRAME_COUNT     = 7'h10;
  localparam logic [6:0] OFS_BUF_READ_ADDR   = 7'h14;
  localparam logic [6:0] OFS_BUF_READ_DATA   = 7'h18;
  localparam logic [6:0] OFS_STATUS          = 7'h1C;
  localparam logic [6:0] OFS_PASS_MASK_BASE  = 7'h40;

  // Field positions inside the 16-bit control registers
  localparam int FLD_LO_MSB  = 7;   // slot_start, frame_length_minus_one,
  localparam int FLD_HI_LSB  = 8;   // frame_interval; slot skip above
  localparam int BIT_ENABLE  = 8;   // strobe_drive_enable / capture_enable

  // Reset values
  localparam logic [15:0] RST_CTRL = 16'h0000;

  // Master sequencer states
  typedef enum logic [2:0] {
    M_IDLE, M_SETUP, M_HIGH, M_LOW, M_HOLD, M_GAP
  } master_state_type;

  // Bus lines entering from the right-hand neighbour
  typedef struct packed {
    logic [7:0] data;
    logic       cell_strobe;
    logic       frame_n;       // Frame window, low true
    logic       sample_clock;
  } bus_in_type;

  // Bus lines driven toward the left-hand neighbours
  typedef struct packed {
    logic [7:0] data;
    logic       data_oe_n;     // Low while data lines are driven
    logic       cell_strobe;
    logic       frame_n;
    logic       sample_clock;
    logic       strobe_oe_n;   // Low while strobe lines are driven
  } bus_out_type;

endpackage
